// ==== verilog/fctd_regs.svh ====
/*
  Constants for the control-plane timing field decoder: field positions,
  code values and timing counts.
  Assumes inclusion by bare name from the decoder module.
*/
`ifndef FCTD_REGS_SVH
`define FCTD_REGS_SVH

// Frame-layout octet split.
`define FCTD_XFORM_MSB 7
`define FCTD_XFORM_LSB 4
`define FCTD_SCS_MSB 3
`define FCTD_SCS_LSB 0

// Transform size codes.
`define FCTD_XFORM_MIN 4'h4
`define FCTD_XFORM_MAX_POW2 4'hc
`define FCTD_XFORM_1536 4'hd
`define FCTD_XFORM_3072 4'he
`define FCTD_SIZE_1536 13'h0600
`define FCTD_SIZE_3072 13'h0c00

// Subcarrier spacing codes.
`define FCTD_SCS_MU_MAX 4'h4
`define FCTD_SCS_LOW_MIN 4'hc

// Section types 0 and 3 carry the prefix length field; type 1 does not.
`define FCTD_SECT_TYPE0 8'h00
`define FCTD_SECT_TYPE1 8'h01
`define FCTD_SECT_TYPE3 8'h03
// Channel-information section, the one that carries a UE count.
`define FCTD_SECT_TYPE6 8'h06

// Longest normal prefix at mu 0, in samples; it halves per mu step.
`define FCTD_NORMAL_PREFIX_MAX 16'h0090

// Symbol base for the second first-length symbol of an NR slot.
`define FCTD_HALF_SLOT_SYMBOL 6'h07

// Sample period 1/30.72 MHz; one sample is 1000/30.72 ns.
`define FCTD_SAMPLE_RATE_KHZ 30720
// Samples in a 1 ms subframe.
`define FCTD_SUBFRAME_SAMPLES 17'h07800

`endif

// ==== verilog/fctd_pkg.sv ====
/*
  Types for the control-plane timing field decoder.
  Assumes fctd_regs.svh sits on the include path.
*/
package fctd_pkg;

  typedef enum logic [1:0] {
    FCTD_IDLE = 2'b00,
    FCTD_UE_WALK = 2'b01
  } fctd_state_type;

  // One received message header.
  typedef struct packed {
    logic [7:0] section_type;
    logic [7:0] frame_layout_octet;
    logic [15:0] slot_time_offset;
    logic [15:0] prefix_length_field;
    logic [5:0] first_symbol_index;
    logic [5:0] slot_index;
    logic [7:0] ue_count;
    logic is_prach;
  } fctd_header_type;

  // Management-plane prefix settings.
  typedef struct packed {
    logic prefix_kind_setting;
    logic [15:0] prefix_length_first;
    logic [15:0] prefix_length_rest;
  } fctd_mplane_type;

  // Decoded timing result.
  typedef struct packed {
    logic [12:0] transform_size;
    logic [2:0] mu;
    logic mu_valid;
    logic [4:0] slots_per_subframe;
    logic [16:0] slot_length_samples;
    logic [15:0] offset_samples;
    logic [15:0] prefix_samples;
    logic prefix_from_field;
    logic prefix_extended;
    logic [5:0] first_symbol_index;
    logic [5:0] slot_index;
    logic [7:0] ue_count;
  } fctd_result_type;

endpackage

// ==== verilog/fctd_decoder.sv ====
/*
  Decoder for the timing and numerology fields of a fronthaul control
  message header, plus a per-UE walker and per-symbol prefix lookup.
  Every header strobe is answered one cycle later by a result pulse or
  by an error pulse; a rejected header leaves the last result on its
  port. An accepted channel-information header that counts UEs starts
  a walk when none is running; the walk counts parsed UE blocks and flags the last one.
  Reset is asynchronous and clears every register and output.
  Assumes a header strobe from same-clock parsing logic and static
  management-plane prefix settings on plain ports.
*/
// Operation
// RULE1: ue count marks last UE parsed
// RULE2: offset counts samples of 1/30.72 MHz
// RULE3: sender keeps offset below slot length
// RULE4: offset refers to first symbol instant
// RULE5: upper nibble transform size, lower spacing
// RULE6: transform size codes decode, others reserved
// RULE7: spacing codes 0..4 give mu
// RULE8: low spacing codes give one slot
// RULE9: size is informative, not a constraint
// RULE10: mu also serves PRACH settings
// RULE11: prefix field counts 30.72 MHz samples
// RULE12: prefix field only for types 0, 3
// RULE13: zero prefix length is legal
// RULE14: prefix kind from length and layout
// RULE15: zero length uses management prefix kind
// RULE16: type 1 uses management prefix lengths
// RULE17: slot index below slots per subframe
// RULE18: reserved codes or late offset flag error
`include "fctd_regs.svh"

module fctd_decoder (
  // Clock and reset.
  input wire logic clock_i,
  input wire logic reset_i,
  // Header in.
  input wire logic header_valid_i,
  input wire fctd_pkg::fctd_header_type header_i,
  // Management-plane settings.
  input wire fctd_pkg::fctd_mplane_type mplane_i,
  // UE walk: one pulse per UE block parsed.
  input wire logic ue_done_i,
  // Symbol prefix lookup.
  input wire logic [5:0] symbol_i,
  output logic [15:0] symbol_prefix_o,
  // Results.
  output logic result_valid_o,
  output fctd_pkg::fctd_result_type result_o,
  output logic error_o,
  output logic last_ue_o,
  output logic ue_walk_busy_o
);
  import fctd_pkg::*;

  //////////////////////////////////////////////////////////////////////
  // Combinational decode of the incoming header.

  logic [3:0] xform_code;
  logic [3:0] scs_code;
  logic [12:0] dec_size;
  logic size_ok;
  logic [2:0] dec_mu;
  logic dec_mu_valid;
  logic scs_ok;
  logic [4:0] dec_slots;
  logic [16:0] dec_slot_len;
  logic offset_ok;
  logic slot_ok;
  logic prefix_applies;
  logic dec_extended;
  logic [15:0] dec_prefix;
  logic dec_from_field;
  logic dec_error;

  assign xform_code = header_i.frame_layout_octet[`FCTD_XFORM_MSB:`FCTD_XFORM_LSB]; // RULE5
  assign scs_code = header_i.frame_layout_octet[`FCTD_SCS_MSB:`FCTD_SCS_LSB]; // RULE5

  // The size is reported only; the transform method is left to the datapath.
  always_comb begin // RULE6 RULE9
    dec_size = 13'h0000;
    size_ok = 1'b1;
    case (xform_code)
      `FCTD_XFORM_MIN, 4'h5, 4'h6, 4'h7, 4'h8, 4'h9, 4'ha, 4'hb, `FCTD_XFORM_MAX_POW2: begin
        dec_size = 13'(13'h0001 << xform_code);
      end
      `FCTD_XFORM_1536: begin
        dec_size = `FCTD_SIZE_1536;
      end
      `FCTD_XFORM_3072: begin
        dec_size = `FCTD_SIZE_3072;
      end
      default: begin
        // Reserved, the no-transform code included.
        size_ok = 1'b0;
      end
    endcase
  end

  // Low spacings have no mu; their mu is treated as zero downstream.
  always_comb begin // RULE7 RULE8 RULE10
    dec_mu = 3'h0;
    dec_mu_valid = 1'b0;
    scs_ok = 1'b1;
    dec_slots = 5'h01;
    case (scs_code)
      4'h0, 4'h1, 4'h2, 4'h3, `FCTD_SCS_MU_MAX: begin
        dec_mu = scs_code[2:0];
        dec_mu_valid = 1'b1;
        dec_slots = 5'(5'h01 << scs_code[2:0]);
      end
      `FCTD_SCS_LOW_MIN, 4'hd, 4'he, 4'hf: begin
        // Below 15 kHz one slot spans the whole subframe.
        dec_slots = 5'h01;
      end
      default: begin
        scs_ok = 1'b0;
      end
    endcase
  end

  // A subframe of samples shared out over its slots gives the slot length.
  assign dec_slot_len = `FCTD_SUBFRAME_SAMPLES >> dec_mu; // RULE7 RULE2
  // The offset is in samples at the first symbol numerology, so it is
  // compared against the slot length of that same numerology.
  assign offset_ok = {1'b0, header_i.slot_time_offset} < dec_slot_len; // RULE3 RULE4 RULE18
  // Low spacings have a single slot, so their slot index must be zero.
  assign slot_ok = {1'b0, header_i.slot_index} < {1'b0, 1'b0, dec_slots}; // RULE17

  assign prefix_applies = header_i.section_type == `FCTD_SECT_TYPE0 ||
                          header_i.section_type == `FCTD_SECT_TYPE3; // RULE12

  // Normal prefix at 30.72 MHz never exceeds 144 samples scaled by mu;
  // a longer field indicates extended prefix.
  always_comb begin // RULE11 RULE13 RULE14 RULE15 RULE16
    dec_prefix = mplane_i.prefix_length_first;
    dec_from_field = 1'b0;
    dec_extended = mplane_i.prefix_kind_setting;
    if (prefix_applies) begin
      dec_prefix = header_i.prefix_length_field;
      dec_from_field = 1'b1;
      if (header_i.prefix_length_field != 16'h0000) begin
        dec_extended = header_i.prefix_length_field > (`FCTD_NORMAL_PREFIX_MAX >> dec_mu);
      end
    end
  end

  assign dec_error = !size_ok || !scs_ok || !offset_ok || !slot_ok; // RULE18

  //////////////////////////////////////////////////////////////////////
  // Acceptance.

  logic accept;
  logic walk_start;

  // Both the result register and the walk take only headers that pass.
  assign accept = header_valid_i && !dec_error; // RULE18
  // Only channel-information sections carry a UE count worth walking.
  assign walk_start = accept && header_i.section_type == `FCTD_SECT_TYPE6 &&
                      header_i.ue_count != 8'h00; // RULE1

  //////////////////////////////////////////////////////////////////////
  // Result register.

  fctd_result_type result;
  fctd_result_type next_result;
  logic result_valid;
  logic next_result_valid;
  logic error;
  logic next_error;

  // A rejected header leaves the result untouched, so consumers keep the
  // last good numerology while the error pulse stands.
  always_comb begin
    next_result = result;
    next_result_valid = 1'b0;
    next_error = 1'b0;
    if (header_valid_i) begin
      if (dec_error) begin
        next_error = 1'b1; // RULE18
      end else begin
        next_result_valid = 1'b1;
        next_result.transform_size = dec_size;
        next_result.mu = dec_mu;
        next_result.mu_valid = dec_mu_valid;
        next_result.slots_per_subframe = dec_slots;
        next_result.slot_length_samples = dec_slot_len;
        next_result.offset_samples = header_i.slot_time_offset; // RULE2 RULE4
        next_result.prefix_samples = dec_prefix;
        next_result.prefix_from_field = dec_from_field;
        next_result.prefix_extended = dec_extended;
        next_result.first_symbol_index = header_i.first_symbol_index;
        next_result.slot_index = header_i.slot_index; // RULE17
        next_result.ue_count = header_i.ue_count; // RULE1
      end
    end
  end

  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      result <= '0;
      result_valid <= 1'b0;
      error <= 1'b0;
    end else begin
      result <= next_result;
      result_valid <= next_result_valid;
      error <= next_error;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // UE walk: counts UE blocks until the count from the header is reached.

  fctd_state_type state;
  fctd_state_type next_state;
  logic [7:0] ue_left;
  logic [7:0] next_ue_left;
  logic last_ue;
  logic next_last_ue;

  // A header during a walk is not a restart; only UE pulses move the count,
  // so a sender that overlaps messages cannot lose the last-UE flag.
  always_comb begin // RULE1
    next_state = state;
    next_ue_left = ue_left;
    next_last_ue = 1'b0;
    case (state)
      FCTD_IDLE: begin
        if (walk_start) begin
          next_state = FCTD_UE_WALK;
          next_ue_left = header_i.ue_count;
        end
      end
      FCTD_UE_WALK: begin
        if (ue_done_i) begin
          next_ue_left = ue_left - 8'h01;
          if (ue_left == 8'h01) begin
            next_last_ue = 1'b1;
            next_state = FCTD_IDLE;
          end
        end
      end
      default: begin
        next_state = FCTD_IDLE;
        next_ue_left = 8'h00;
      end
    endcase
  end

  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      state <= FCTD_IDLE;
      ue_left <= 8'h00;
      last_ue <= 1'b0;
    end else begin
      state <= next_state;
      ue_left <= next_ue_left;
      last_ue <= next_last_ue;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Per-symbol prefix length for the accepted message.

  logic [9:0] second_first_symbol;
  logic [15:0] next_symbol_prefix;
  logic [15:0] symbol_prefix;

  // Mu of a low spacing is zero, which gives symbol 7. The product is kept
  // wide so that symbol 112 at mu 4 cannot alias onto symbol 48.
  assign second_first_symbol = 10'({4'h0, `FCTD_HALF_SLOT_SYMBOL} << result.mu); // RULE16

  // Management lengths are read live, so a change there shows one cycle on.
  always_comb begin
    if (result.prefix_from_field) begin
      next_symbol_prefix = result.prefix_samples; // RULE12
    end else if (symbol_i == 6'h00 || {4'h0, symbol_i} == second_first_symbol) begin
      next_symbol_prefix = mplane_i.prefix_length_first; // RULE16
    end else begin
      next_symbol_prefix = mplane_i.prefix_length_rest; // RULE16
    end
  end

  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      symbol_prefix <= 16'h0000;
    end else begin
      symbol_prefix <= next_symbol_prefix;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Outputs; busy is a level taken straight from the state register.

  assign result_o = result;
  assign result_valid_o = result_valid;
  assign error_o = error;
  assign last_ue_o = last_ue;
  assign ue_walk_busy_o = state == FCTD_UE_WALK;
  assign symbol_prefix_o = symbol_prefix;

endmodule

// ==== dv/fctd_checker.sv ====
/*
  Port checker for fctd_decoder.
  Assumes one clock and the async reset_i.
*/
module fctd_checker (
  // Clock and reset.
  input wire logic clock_i,
  input wire logic reset_i,
  // Inputs seen.
  input wire logic header_valid_i,
  input wire fctd_pkg::fctd_header_type header_i,
  input wire fctd_pkg::fctd_mplane_type mplane_i,
  input wire logic ue_done_i,
  input wire logic [5:0] symbol_i,
  // Outputs seen.
  input wire logic [15:0] symbol_prefix_o,
  input wire logic result_valid_o,
  input wire fctd_pkg::fctd_result_type result_o,
  input wire logic error_o,
  input wire logic last_ue_o,
  input wire logic ue_walk_busy_o
);
  timeunit 1ns;
  timeprecision 1ps;
  import fctd_pkg::*;
  default clocking @(posedge clock_i); endclocking
  default disable iff (reset_i);
  logic [3:0] xc;
  logic [3:0] sc;
  assign xc = header_i.frame_layout_octet[7:4];
  assign sc = header_i.frame_layout_octet[3:0];
  sequence hdr_s;
    header_valid_i;
  endsequence
  sequence rej_s;
    error_o && !result_valid_o;
  endsequence
  hdr_answer_a: assert property (hdr_s |=> result_valid_o ^ error_o)
    else $error("header not answered");
  no_stray_a: assert property (result_valid_o || error_o |-> $past(header_valid_i))
    else $error("answer without header");
  bad_size_a: assert property (hdr_s ##0 (xc < 4'h4 || xc == 4'hf) |=> rej_s)
    else $error("reserved size accepted");
  bad_spacing_a: assert property (hdr_s ##0 (sc > 4'h4 && sc < 4'hc) |=> rej_s)
    else $error("reserved spacing accepted");
  late_offset_a: assert property (hdr_s ##0 (sc < 4'h5 &&
    {1'b0, header_i.slot_time_offset} >= (17'h07800 >> sc)) |=> rej_s)
    else $error("late offset accepted");
  slot_count_a: assert property (result_valid_o |-> result_o.slots_per_subframe ==
    (result_o.mu_valid ? 5'(1 << result_o.mu) : 5'h01))
    else $error("slot count wrong");
  result_kept_a: assert property (error_o |-> $stable(result_o))
    else $error("result changed on error");
  zero_prefix_a: assert property (result_valid_o && result_o.prefix_from_field &&
    result_o.prefix_samples == 16'h0000 |->
    result_o.prefix_extended == mplane_i.prefix_kind_setting)
    else $error("zero prefix kind wrong");
  walk_type_a: assert property (hdr_s ##0 (header_i.section_type != 8'h06 &&
    !ue_walk_busy_o) |=> !ue_walk_busy_o)
    else $error("walk started by wrong section");
  last_ue_a: assert property (last_ue_o |-> !ue_walk_busy_o && $past(ue_done_i) &&
    $past(ue_walk_busy_o))
    else $error("last ue misplaced");
endmodule
bind fctd_decoder fctd_checker i_chk (.*);

// ==== dv/fctd_du_model.sv ====
/*
  Sender model: drives headers and UE-parsed pulses.
  Assumes the caller runs tasks in time order.
*/
module fctd_du_model (
  // Clock.
  input wire logic clock_i,
  // Message side.
  output logic header_valid_o,
  output fctd_pkg::fctd_header_type header_o,
  output logic ue_done_o
);
  timeunit 1ns;
  timeprecision 1ps;
  import fctd_pkg::*;
  initial begin
    header_valid_o = 1'b0;
    header_o = '0;
    ue_done_o = 1'b0;
  end
  // Callers keep offset and slot index legal unless a refusal is meant.
  task automatic send(input fctd_header_type h);
    @(negedge clock_i);
    header_valid_o = 1'b1;
    header_o = h;
    @(negedge clock_i);
    header_valid_o = 1'b0;
    header_o = ~h;
  endtask
  // One pulse per UE block, as many as the header counted.
  task automatic ue();
    @(negedge clock_i);
    ue_done_o = 1'b1;
    @(negedge clock_i);
    ue_done_o = 1'b0;
  endtask
endmodule

// ==== dv/fctd_decoder_bench.sv ====
/*
  Self-checking bench for fctd_decoder.
  Assumes fctd_du_model drives the header side.
*/
module fctd_decoder_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import fctd_pkg::*;
  logic clock_i = 1'b0;
  logic reset_i = 1'b1;
  logic hv;
  logic ue_d;
  logic [5:0] sym = 6'h00;
  logic [15:0] pf;
  logic rv;
  logic er;
  logic lu;
  logic bsy;
  fctd_header_type h;
  fctd_result_type r;
  fctd_mplane_type mp = '{1'b1, 16'h0048, 16'h0024};
  int bad_count = 0;
  int comparisons = 0;
  fctd_du_model i_du (.clock_i(clock_i), .header_valid_o(hv), .header_o(h), .ue_done_o(ue_d));
  fctd_decoder i_dut (.clock_i(clock_i), .reset_i(reset_i), .header_valid_i(hv),
    .header_i(h), .mplane_i(mp), .ue_done_i(ue_d), .symbol_i(sym), .symbol_prefix_o(pf),
    .result_valid_o(rv), .result_o(r), .error_o(er), .last_ue_o(lu), .ue_walk_busy_o(bsy));
  initial forever #2 clock_i = ~clock_i;
  task automatic chk(input logic [16:0] g, input logic [16:0] e);
    comparisons++;
    if (g !== e) begin
      bad_count++;
      $display("[ERR] %0t got %h want %h", $time, g, e);
    end
  endtask
  task automatic report_and_stop();
    if (bad_count == 0 && comparisons > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic go(input logic [7:0] st, input logic [7:0] lay, input logic [15:0] off,
    input logic [15:0] pl, input logic [5:0] sl, input logic [7:0] n);
    i_du.send('{st, lay, off, pl, 6'h00, sl, n, 1'b0});
  endtask
  task automatic look(input logic [5:0] s, input logic [16:0] e);
    @(negedge clock_i);
    sym = s;
    @(negedge clock_i);
    chk(17'(pf), e);
  endtask
  initial begin
    #20000;
    bad_count++;
    report_and_stop();
  end
  initial begin
    repeat (4) @(negedge clock_i);
    reset_i = 1'b0;
    chk(17'({rv, er, bsy}), 17'h0);
    for (int c = 0; c < 16; c++) begin
      go(8'h00, 8'(c << 4), 16'h0000, 16'h0000, 6'h00, 8'h00);
      if (c < 4 || c == 15) chk(17'(er), 17'h1);
      else chk(17'(r.transform_size), c == 13 ? 17'h0600 : c == 14 ? 17'h0c00 : 17'(1 << c));
    end
    for (int c = 0; c < 16; c++) begin
      go(8'h00, 8'ha0 | 8'(c), 16'h0000, 16'h0000, 6'h00, 8'h00);
      if (c > 4 && c < 12) chk(17'(er), 17'h1);
      else begin
        chk(17'(r.mu_valid), 17'(c < 5));
        chk(17'(r.slots_per_subframe), c < 5 ? 17'(1 << c) : 17'h1);
        chk(r.slot_length_samples, c < 5 ? 17'h07800 >> c : 17'h07800);
        if (c < 5) chk(17'(r.mu), 17'(c));
      end
    end
    go(8'h00, 8'ha1, 16'h3bff, 16'h0000, 6'h01, 8'h00);
    chk(17'(r.offset_samples), 17'h3bff);
    chk(17'(r.slot_index), 17'h1);
    go(8'h00, 8'ha1, 16'h3c00, 16'h0000, 6'h00, 8'h00);
    chk(17'(er), 17'h1);
    chk(17'(r.offset_samples), 17'h3bff);
    go(8'h00, 8'ha0, 16'h0000, 16'h0000, 6'h01, 8'h00);
    chk(17'(er), 17'h1);
    go(8'h00, 8'ha0, 16'h0000, 16'h0120, 6'h00, 8'h00);
    chk(17'(r.prefix_samples), 17'h0120);
    chk(17'(r.prefix_extended), 17'h1);
    go(8'h03, 8'ha0, 16'h0000, 16'h0048, 6'h00, 8'h00);
    chk(17'({r.prefix_from_field, r.prefix_extended}), 17'h2);
    look(6'h05, 17'h0048);
    go(8'h00, 8'ha0, 16'h0000, 16'h0000, 6'h00, 8'h00);
    chk(17'({rv, r.prefix_extended}), 17'h3);
    go(8'h01, 8'ha1, 16'h0000, 16'h0120, 6'h00, 8'h00);
    chk(17'({r.prefix_from_field, r.prefix_samples}), 17'h0048);
    look(6'h00, 17'h0048);
    look(6'h0e, 17'h0048);
    look(6'h07, 17'h0024);
    go(8'h00, 8'ha0, 16'h0000, 16'h0000, 6'h00, 8'h02);
    chk(17'(bsy), 17'h0);
    go(8'h06, 8'ha0, 16'h0000, 16'h0000, 6'h00, 8'h02);
    chk(17'({bsy, r.ue_count}), 17'h102);
    i_du.ue();
    chk(17'({bsy, lu}), 17'h2);
    i_du.ue();
    chk(17'({bsy, lu}), 17'h1);
    i_du.send('{8'h01, 8'ha4, 16'h0100, 16'h0000, 6'h05, 6'h0f, 8'h00, 1'b0});
    chk(17'(r.first_symbol_index), 17'h5);
    look(6'h30, 17'h0024);
    go(8'h06, 8'ha0, 16'h0000, 16'h0000, 6'h00, 8'h03);
    i_du.ue();
    @(negedge clock_i);
    reset_i = 1'b1;
    @(negedge clock_i);
    reset_i = 1'b0;
    chk(17'({rv, er, bsy, lu}), 17'h0);
    chk(17'(pf), 17'h0);
    chk(r.slot_length_samples, 17'h0);
    go(8'h00, 8'ha2, 16'h0000, 16'h0000, 6'h03, 8'h00);
    chk(17'({rv, r.slots_per_subframe}), 17'h24);
    report_and_stop();
  end
endmodule
